// ### rtl/qpg_defs.vh
/*
 * qpg_defs.vh: register offsets, field positions, reset values and
 * prescaler taps of the four-channel pulse-width modulator.
 * Assumes a 32-bit bus with one aligned word per register; only the low
 * address byte is decoded.
 */
`ifndef QPG_DEFS_VH
`define QPG_DEFS_VH

// byte offsets of the registers
`define QPG_OFF_RELOAD0   8'h00
`define QPG_OFF_RELOAD1   8'h04
`define QPG_OFF_RELOAD2   8'h08
`define QPG_OFF_RELOAD3   8'h0c
`define QPG_OFF_CTL01     8'h10
`define QPG_OFF_CTL23     8'h14
`define QPG_OFF_CMPTMR0   8'h18
`define QPG_OFF_CMPTMR1   8'h1c
`define QPG_OFF_CMPTMR2   8'h20
`define QPG_OFF_CMPTMR3   8'h24
`define QPG_OFF_JOIN      8'h28
`define QPG_OFF_CLKSEL    8'h2c

// channel nibble inside a control register: even channel high, odd low
`define QPG_CTL_EVEN_LSB  4
`define QPG_CTL_ODD_LSB   0
// bit positions within a channel nibble
`define QPG_CTL_TC        0
`define QPG_CTL_OE        1
`define QPG_CTL_FH        2
`define QPG_CTL_FLAG      3

// clock-select register: one nibble per channel, select in [2:0]
`define QPG_CS_EN         3
`define QPG_CS_EXT        2

// prescaler taps, select codes 000..011
`define QPG_SEL_DIV1      2'b00
`define QPG_SEL_DIV4      2'b01
`define QPG_SEL_DIV16     2'b10
`define QPG_SEL_DIV64     2'b11
`define QPG_PRE_W         6

// reset values and timer top count
`define QPG_RST_BYTE      8'h00
`define QPG_RST_RDATA     32'h0000_0000
`define QPG_TOP_COUNT     8'hff

// bus encodings
`define QPG_HRESP_OKAY    1'b0

`endif

// ### rtl/qpg_top.v
/*
 * qpg_top.v: four-channel 8-bit pulse-width modulator with shared
 * prescaler, per-channel reloadable dividers and pair joining to 16 bits,
 * reached as a zero-wait AHB-Lite slave.
 * Assumes one clock mclk, synchronous active-high rst, and that the two
 * external clock pins hold each level for at least two mclk cycles.
 */
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "qpg_defs.vh"

// How it works
// [R1] divider passes one clock in reload plus one; zero passes every clock
// [R2] each channel owns a writable 8-bit frequency reload register
// [R3] divider runs only while its enable bit is set; reset clears it
// [R4] pin shows the signal only while output enable is set; reset clears it
// [R5] value register reaches compare when select is 0, timer when 1
// [R6] timer counts on divided clock; wrap from top to zero sets output
// [R7] after a wrap the output clears when timer equals compare
// [R8] compare of zero keeps the output low, no pulse at the wrap
// [R9] force-high bit holds the output at one
// [R10] wrap sets a sticky rollover flag until software clears it
// [R11] join bit 0 pairs channels 0 and 1, bit 1 pairs channels 2 and 3
// [R12] joined pair runs on the even channel divider; odd divider idles
// [R13] joined pair keeps the 8-bit reload and the same division
// [R14] joined timers chain into 16 bits; set at zero, clear at match
// [R15] prescaler unchanged by joining and feeds all four dividers
// [R16] prescaler gives clock divided by 1, 4, 16 and 64
// [R17] select 000..011 picks a prescaler tap, top bit set picks external
// [R18] external clocks pass two flip-flops before use
// [R19] joined match is odd compare as high byte, even compare as low
module qpg_top (
    input  wire        mclk,
    input  wire        rst,
    input  wire        ce,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    input  wire        ext_clock_in_a,
    input  wire        ext_clock_in_b,
    output reg         chan0_output_pin,
    output reg         chan1_output_pin,
    output reg         chan2_output_pin,
    output reg         chan3_output_pin
);

    reg  [7:0]  reload_r [0:3];
    reg  [7:0]  cmp_r    [0:3];
    reg  [7:0]  tmr_r    [0:3];
    reg  [7:0]  divc_r   [0:3];
    reg  [3:0]  clksel_r [0:3];
    reg  [3:0]  oe_r;
    reg  [3:0]  tcs_r;
    reg  [3:0]  fh_r;
    reg  [3:0]  flag_r;
    reg  [3:0]  out_r;
    reg  [1:0]  join_r;
    reg  [`QPG_PRE_W-1:0] pre_r;
    reg  [2:0]  exa_r;
    reg  [2:0]  exb_r;
    reg         wr_pend_r;
    reg  [7:0]  wa_r;

    reg  [3:0]  div_on;
    reg  [3:0]  ctick;
    reg  [3:0]  dpul;
    reg  [3:0]  inc;
    reg  [3:0]  wrap;
    reg  [3:0]  wr_rel;
    reg  [3:0]  wr_cv;
    reg  [3:0]  wr_ctl;
    reg  [3:0]  ctl_nib [0:3];
    reg  [31:0] rd_nxt;

    wire        ea_t;
    wire        eb_t;
    wire        acc;
    wire        wv;
    wire [7:0]  ra;

    integer     i;
    integer     j;
    integer     k;
    integer     m;
    integer     n;

    // tick of the source picked by a channel clock select
    function sel_tick;
        input [2:0]            sel;
        input                  ext;
        input [`QPG_PRE_W-1:0] pre;
        begin
            if (sel[`QPG_CS_EXT]) begin
                sel_tick = ext; // [R17]
            end else begin
                case (sel[1:0])
                    `QPG_SEL_DIV1:  sel_tick = 1'b1; // [R16]
                    `QPG_SEL_DIV4:  sel_tick = &pre[1:0];
                    `QPG_SEL_DIV16: sel_tick = &pre[3:0];
                    default:        sel_tick = &pre;
                endcase
            end
        end
    endfunction

    // byte offset of a per-channel register
    function [7:0] ch_off;
        input [7:0] base;
        input [1:0] ch;
        begin
            ch_off = base + {4'h0, ch, 2'b00};
        end
    endfunction

    // edge of the second synchroniser stage only
    assign ea_t = exa_r[1] & ~exa_r[2]; // [R18]
    assign eb_t = exb_r[1] & ~exb_r[2];
    assign acc  = hsel & htrans[1] & hready;
    assign wv   = wr_pend_r;
    assign ra   = {haddr[7:2], 2'b00};

    // divider ticks, timer increments and write strobes
    always @* begin
        div_on = 4'h0;
        ctick  = 4'h0;
        dpul   = 4'h0;
        inc    = 4'h0;
        wrap   = 4'h0;
        wr_rel = 4'h0;
        wr_cv  = 4'h0;
        wr_ctl = 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
            div_on[i] = clksel_r[i][`QPG_CS_EN] & ~(i[0] & join_r[i/2]); // [R3] [R12]
            ctick[i]  = div_on[i] & sel_tick(clksel_r[i][2:0], // [R15]
                            (i < 2) ? ea_t : eb_t, pre_r);
            dpul[i]   = ctick[i] & (divc_r[i] == reload_r[i]); // [R1] [R13]
            wr_rel[i] = wv & (wa_r == ch_off(`QPG_OFF_RELOAD0, i[1:0])); // [R2]
            wr_cv[i]  = wv & (wa_r == ch_off(`QPG_OFF_CMPTMR0, i[1:0]));
            wr_ctl[i] = wv & (wa_r == (i < 2 ? `QPG_OFF_CTL01 : `QPG_OFF_CTL23));
            ctl_nib[i] = i[0] ? hwdata[`QPG_CTL_ODD_LSB +: 4]
                              : hwdata[`QPG_CTL_EVEN_LSB +: 4];
        end
        for (j = 0; j < 2; j = j + 1) begin
            inc[2*j] = dpul[2*j]; // [R6]
            if (join_r[j]) begin
                inc[2*j+1] = dpul[2*j] & (tmr_r[2*j] == `QPG_TOP_COUNT); // [R14]
            end else begin
                inc[2*j+1] = dpul[2*j+1];
            end
        end
        for (i = 0; i < 4; i = i + 1) begin
            wrap[i] = inc[i] & (tmr_r[i] == `QPG_TOP_COUNT);
        end
    end

    // read data for the address phase
    always @* begin
        rd_nxt = `QPG_RST_RDATA;
        case (ra)
            `QPG_OFF_RELOAD0: rd_nxt[7:0] = reload_r[0];
            `QPG_OFF_RELOAD1: rd_nxt[7:0] = reload_r[1];
            `QPG_OFF_RELOAD2: rd_nxt[7:0] = reload_r[2];
            `QPG_OFF_RELOAD3: rd_nxt[7:0] = reload_r[3];
            `QPG_OFF_CTL01: begin
                rd_nxt[7:0] = {flag_r[0], fh_r[0], oe_r[0], tcs_r[0],
                               flag_r[1], fh_r[1], oe_r[1], tcs_r[1]};
            end
            `QPG_OFF_CTL23: begin
                rd_nxt[7:0] = {flag_r[2], fh_r[2], oe_r[2], tcs_r[2],
                               flag_r[3], fh_r[3], oe_r[3], tcs_r[3]};
            end
            `QPG_OFF_CMPTMR0: rd_nxt[7:0] = tcs_r[0] ? tmr_r[0] : cmp_r[0]; // [R5]
            `QPG_OFF_CMPTMR1: rd_nxt[7:0] = tcs_r[1] ? tmr_r[1] : cmp_r[1];
            `QPG_OFF_CMPTMR2: rd_nxt[7:0] = tcs_r[2] ? tmr_r[2] : cmp_r[2];
            `QPG_OFF_CMPTMR3: rd_nxt[7:0] = tcs_r[3] ? tmr_r[3] : cmp_r[3];
            `QPG_OFF_JOIN:    rd_nxt[1:0] = join_r;
            `QPG_OFF_CLKSEL: begin
                rd_nxt[15:0] = {clksel_r[3], clksel_r[2],
                                clksel_r[1], clksel_r[0]};
            end
            default:          rd_nxt = `QPG_RST_RDATA;
        endcase
    end

    always @(posedge mclk) begin
        if (rst) begin
            hreadyout        <= 1'b1;
            hresp            <= `QPG_HRESP_OKAY;
            hrdata           <= `QPG_RST_RDATA;
            wr_pend_r        <= 1'b0;
            wa_r             <= `QPG_RST_BYTE;
            pre_r            <= {`QPG_PRE_W{1'b0}};
            exa_r            <= 3'b000;
            exb_r            <= 3'b000;
            oe_r             <= 4'h0;
            tcs_r            <= 4'h0;
            fh_r             <= 4'h0;
            flag_r           <= 4'h0;
            out_r            <= 4'h0;
            join_r           <= 2'b00;
            chan0_output_pin <= 1'b0;
            chan1_output_pin <= 1'b0;
            chan2_output_pin <= 1'b0;
            chan3_output_pin <= 1'b0;
            for (k = 0; k < 4; k = k + 1) begin
                reload_r[k] <= `QPG_RST_BYTE;
                cmp_r[k]    <= `QPG_RST_BYTE;
                tmr_r[k]    <= `QPG_RST_BYTE;
                divc_r[k]   <= `QPG_RST_BYTE;
                clksel_r[k] <= 4'h0; // [R3]
            end
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp     <= `QPG_HRESP_OKAY;
            pre_r     <= pre_r + {{(`QPG_PRE_W-1){1'b0}}, 1'b1}; // [R16]
            exa_r     <= {exa_r[1:0], ext_clock_in_a}; // [R18]
            exb_r     <= {exb_r[1:0], ext_clock_in_b};

            // bus: read data taken at address phase, write at data phase
            wr_pend_r <= acc & hwrite;
            if (acc) begin
                wa_r <= ra;
            end
            if (acc & ~hwrite) begin
                hrdata <= rd_nxt;
            end
            if (wv & (wa_r == `QPG_OFF_JOIN)) begin
                join_r <= hwdata[1:0]; // [R11]
            end
            if (wv & (wa_r == `QPG_OFF_CLKSEL)) begin
                for (k = 0; k < 4; k = k + 1) begin
                    clksel_r[k] <= hwdata[4*k +: 4]; // [R17]
                end
            end

            for (k = 0; k < 4; k = k + 1) begin
                if (wr_rel[k]) begin
                    reload_r[k] <= hwdata[7:0]; // [R2]
                end
                // divider: counts source ticks, restarts after reload value
                if (~div_on[k]) begin
                    divc_r[k] <= `QPG_RST_BYTE; // [R12]
                end else if (ctick[k]) begin
                    divc_r[k] <= dpul[k] ? `QPG_RST_BYTE
                                         : divc_r[k] + 8'h01; // [R1]
                end
                // value register: bus write wins over counting
                if (wr_cv[k] & tcs_r[k]) begin
                    tmr_r[k] <= hwdata[7:0]; // [R5]
                end else if (inc[k]) begin
                    tmr_r[k] <= tmr_r[k] + 8'h01; // [R6] [R14]
                end
                if (wr_cv[k] & ~tcs_r[k]) begin
                    cmp_r[k] <= hwdata[7:0]; // [R5]
                end
                if (wr_ctl[k]) begin
                    tcs_r[k] <= ctl_nib[k][`QPG_CTL_TC];
                    oe_r[k]  <= ctl_nib[k][`QPG_CTL_OE]; // [R4]
                    fh_r[k]  <= ctl_nib[k][`QPG_CTL_FH]; // [R9]
                end
                // sticky flag: set wins, software writes 0 to clear
                if (wrap[k]) begin
                    flag_r[k] <= 1'b1; // [R10]
                end else if (wr_ctl[k] & ~ctl_nib[k][`QPG_CTL_FLAG]) begin
                    flag_r[k] <= 1'b0;
                end
            end

            // modulated level, per pair; own loop indices, not shared with the decode
            for (n = 0; n < 2; n = n + 1) begin
                if (join_r[n]) begin
                    out_r[2*n+1] <= 1'b0;
                    if ({cmp_r[2*n+1], cmp_r[2*n]} == 16'h0000) begin
                        out_r[2*n] <= 1'b0; // [R8]
                    end else if (wrap[2*n+1]) begin
                        out_r[2*n] <= 1'b1; // [R14]
                    end else if (inc[2*n] &
                                 ({tmr_r[2*n+1], tmr_r[2*n]} + 16'h0001 ==
                                  {cmp_r[2*n+1], cmp_r[2*n]})) begin
                        out_r[2*n] <= 1'b0; // [R19]
                    end
                end else begin
                    for (m = 2*n; m < 2*n + 2; m = m + 1) begin
                        if (cmp_r[m] == `QPG_RST_BYTE) begin
                            out_r[m] <= 1'b0; // [R8]
                        end else if (wrap[m]) begin
                            out_r[m] <= 1'b1; // [R6]
                        end else if (inc[m] &
                                     (tmr_r[m] + 8'h01 == cmp_r[m])) begin
                            out_r[m] <= 1'b0; // [R7]
                        end
                    end
                end
            end

            chan0_output_pin <= oe_r[0] & (fh_r[0] | out_r[0]); // [R4] [R9]
            chan1_output_pin <= oe_r[1] & (fh_r[1] | out_r[1]);
            chan2_output_pin <= oe_r[2] & (fh_r[2] | out_r[2]);
            chan3_output_pin <= oe_r[3] & (fh_r[3] | out_r[3]);
        end
    end

endmodule
`default_nettype wire

// ### sim/qpg_ext_src.sv
/* qpg_ext_src.sv: source of the two external clock pins.
   Assumes go pulses for one cycle; both lines idle low. */
`timescale 1ns/1ps
`default_nettype none
module qpg_ext_src #(
    parameter int HALF = 3
) (
    input  wire logic       mclk,
    input  wire logic       go,
    input  wire logic       sel_b,
    input  wire logic [7:0] n_edges,
    output var logic        ext_a,
    output var logic        ext_b,
    output var logic        busy
);
    initial begin
        ext_a = 1'b0;
        ext_b = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge mclk);
            if (go) begin
                busy <= 1'b1;
                repeat (n_edges) begin
                    // each level held HALF cycles, never under two
                    repeat (HALF) @(posedge mclk);
                    if (sel_b) ext_b <= 1'b1;
                    else ext_a <= 1'b1;
                    repeat (HALF) @(posedge mclk);
                    ext_a <= 1'b0;
                    ext_b <= 1'b0;
                end
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/qpg_top_monitor.sv
/* qpg_top_monitor.sv: port-level assertions on the modulator top.
   Assumes hready is tied to hreadyout and a single clock mclk. */
`timescale 1ns/1ps
`default_nettype none
module qpg_mon (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        chan0_output_pin,
    input wire logic        chan1_output_pin,
    input wire logic        chan2_output_pin,
    input wire logic        chan3_output_pin
);
    wire [3:0] pins = {chan3_output_pin, chan2_output_pin, chan1_output_pin, chan0_output_pin};
    wire       take_rd = hsel & htrans[1] & hready & ce & ~hwrite;
    wire       unm_rd = take_rd & (haddr[7:2] > 6'h0b);
    wire       byte_rd = take_rd & (haddr[7:2] < 6'h0b);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("hreadyout dropped");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_pins_rst; $fell(rst) |-> (pins == 4'h0) [*3]; endproperty
    a_pins_rst: assert property (p_pins_rst) else $error("pin high after reset");
    property p_rd_rst; $fell(rst) |-> hrdata == 32'h0; endproperty
    a_rd_rst: assert property (p_rd_rst) else $error("read data not cleared");
    property p_freeze; !ce |=> $stable(hrdata) && $stable(pins); endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with ce low");
    property p_rd_cause; $changed(hrdata) |-> $past(take_rd) || $past(rst); endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("read data changed unasked");
    property p_unmapped; $past(unm_rd) |-> hrdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_narrow; $past(byte_rd) |-> hrdata[31:8] == 24'h0; endproperty
    a_narrow: assert property (p_narrow) else $error("upper read bits set");
endmodule
bind qpg_top qpg_mon u_mon (.mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .chan0_output_pin(chan0_output_pin),
    .chan1_output_pin(chan1_output_pin), .chan2_output_pin(chan2_output_pin),
    .chan3_output_pin(chan3_output_pin));
`default_nettype wire

// ### sim/tb_quad_pwm_clock_pulse_gen.sv
/* tb_quad_pwm_clock_pulse_gen.sv: self-checking bench of the modulator.
   Assumes the zero-wait slave and the external clock source model. */
`timescale 1ns/1ps
`default_nettype none
module tb_quad_pwm_clock_pulse_gen;
    logic        mclk, rst, ce, hsel, hwrite, go, sel_b;
    logic [1:0]  htrans;
    logic [7:0]  n_edges;
    logic [15:0] lfsr;
    logic [31:0] haddr, hwdata, rd;
    logic [31:0] cnt [4];
    logic [7:0]  cmp [4];
    wire  [31:0] hrdata;
    wire  [3:0]  pin;
    wire         hreadyout, hresp, ext_a, ext_b, busy;
    int          n_fail, compares;
    qpg_top uut (.mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ext_clock_in_a(ext_a), .ext_clock_in_b(ext_b), .chan0_output_pin(pin[0]),
        .chan1_output_pin(pin[1]), .chan2_output_pin(pin[2]), .chan3_output_pin(pin[3]));
    qpg_ext_src src (.mclk(mclk), .go(go), .sel_b(sel_b), .n_edges(n_edges),
        .ext_a(ext_a), .ext_b(ext_b), .busy(busy));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // high cycles in a 16384-cycle window: compare times 64
    function logic [31:0] exp_hi(input logic [7:0] c);
        return {18'h0, c, 6'h0};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task reset_dut;
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
    endtask
    task count(input int n);
        for (int i = 0; i < 4; i++) cnt[i] = 32'h0;
        repeat (n) begin
            @(posedge mclk);
            for (int i = 0; i < 4; i++) cnt[i] = cnt[i] + pin[i];
        end
    endtask
    task conclude;
        if (n_fail == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge mclk);
        n_fail++;
        conclude;
    end
    initial begin
        rst = 1'b1;
        ce = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwdata = 32'h0;
        go = 1'b0;
        sel_b = 1'b0;
        n_edges = 8'h0;
        lfsr = 16'h9420;
        @(posedge mclk);
        reset_dut;
        repeat (3) @(posedge mclk);
        ce <= 1'b1;
        for (int a = 0; a <= 48; a += 4) rc(8'(a), 32'h0);
        wr(8'h28, 32'hffffffff);
        rc(8'h28, 32'h3);
        wr(8'h28, 32'h0);
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            cmp[i] = (i == 3) ? 8'h0 : lfsr[7:0];
            wr(8'(4 * i), {24'hffffff, lfsr[15:8]});
            rc(8'(4 * i), {24'h0, lfsr[15:8]});
            wr(8'(4 * i), (i == 0) ? 32'h3 : 32'h0);
            wr(8'(24 + 4 * i), {24'h0, cmp[i]});
            rc(8'(24 + 4 * i), {24'h0, cmp[i]});
        end
        wr(8'h10, 32'h22);
        wr(8'h14, 32'h22);
        wr(8'h2c, 32'hba98);
        repeat (16384) @(posedge mclk);
        count(16384);
        for (int i = 0; i < 4; i++) chk(cnt[i], exp_hi(cmp[i]));
        wr(8'h2c, 32'h0);
        rc(8'h10, 32'haa);
        rc(8'h14, 32'haa);
        wr(8'h10, 32'h22);
        rc(8'h10, 32'h22);
        wr(8'h14, 32'h66);
        repeat (3) @(posedge mclk);
        chk({30'h0, pin[3:2]}, 32'h3);
        reset_dut;
        wr(8'h28, 32'h1);
        wr(8'h10, 32'h33);
        wr(8'h18, 32'hf0);
        wr(8'h1c, 32'hff);
        wr(8'h10, 32'h22);
        wr(8'h18, 32'h10);
        wr(8'h1c, 32'h01);
        wr(8'h2c, 32'h8);
        count(1000);
        chk(cnt[0], 32'h0110);
        chk(cnt[1], 32'h0);
        reset_dut;
        for (int k = 0; k < 2; k++) begin
            lfsr = nxt(lfsr);
            n_edges <= {2'b0, lfsr[5:0]} + 8'h1;
            sel_b <= k[0];
            wr(8'(16 + 4 * k), 32'h10);
            wr(8'h2c, (k == 1) ? 32'hc00 : 32'hc);
            go <= 1'b1;
            @(posedge mclk);
            go <= 1'b0;
            @(posedge mclk);
            while (busy) @(posedge mclk);
            repeat (5) @(posedge mclk);
            rc(8'(24 + 8 * k), {26'h0, lfsr[5:0]} + 32'h1);
        end
        conclude;
    end
endmodule
`default_nettype wire
